// file: rx_ctrl_defs.svh
// Purpose: Constants for the receive port and the serial register port.
// Assumes: A 20 MHz i_clk standing in for the master clock.
// Notes: Definitions only.
`ifndef RX_CTRL_DEFS_SVH
`define RX_CTRL_DEFS_SVH
`define BIT_LAST 3'h7
`define IDX_HI 6
`define IDX_LO 2
`define CFG_INV_IDX 5'h01
`define CFG_INV_BIT 0
`define PE_HOLD 2'h2
`define RX_BIT_CLOCK_HI 4'h2
`endif

// file: rx_ctrl_pkg.sv
// Purpose: Types shared by the receive and serial register port logic.
// Assumes: Nothing beyond the defs header.
// Notes: Demodulator strobes arrive on i_clk.
package rx_ctrl_pkg;
    typedef struct packed {
        logic start_of_frame_mark;
        logic bit_stb;
        logic bit_val;
        logic crc_phase;
        logic hdr_err;
    } demod_t;
    typedef enum logic [1:0] {
        SP_IDLE = 2'h0,
        SP_ADDR = 2'h1,
        SP_DATA = 2'h3,
        SP_DONE = 2'h2
    } sp_state_t;
endpackage

// file: baseband_host_rx_ctrl_ports.sv
// Purpose: Receive data port and four-wire serial register port.
// Assumes: Demodulator strobes on i_clk; port pins are asynchronous.
// Notes: Register contents survive reset and must be programmed.
// Overview of operation
// R1 - Bit clock output carries header and payload at the current bit rate.
// R2 - Bit clock held low during the header checksum.
// R3 - Bit clock toggles only after the start-of-frame mark.
// R4 - Host samples on rising edge; a register bit inverts the clock.
// R5 - Frame-valid is active high and envelopes header and data.
// R6 - Frame-valid set on frame mark, cleared by power-enable low or header error.
// R7 - Power-enable active high; low keeps converters disabled.
// R8 - Serial register words move most significant bit first.
// R9 - Eight address bits then eight data bits per transfer.
// R10 - Serial data clocked on rising serial clock edges.
// R11 - Host keeps serial clock at most 11 MHz and half master clock.
// R12 - Read/write select high reads, low writes, sets line direction.
// R13 - Select settles before the edge and enables read shifting.
// R14 - Port select high makes data, clock and select ignored.
// R15 - Port select does not affect the receive port.
// R16 - Host drives the spare serial input to a defined level.
// R17 - Reset disables receive and keeps standby.
// R18 - Reset leaves register contents untouched.
// R19 - Power-enable held two clocks after reset before receive resumes.
// R20 - Transceiver clocks derive from master clock divided by two and four.
// R21 - Port select high resets the serial port state machine.
// R22 - Host keeps master clock running while programming.
// R23 - Two address low bits are ignored.
// R24 - Receive line sends least significant bit first within the frame.
// R25 - In reads the line is released during address, driven for data.
`timescale 1ns/10ps
`include "rx_ctrl_defs.svh"
module baseband_host_rx_ctrl_ports
    import rx_ctrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_rx_power_enable,
    input wire demod_t i_demod,
    input wire logic i_sclk,
    input wire logic i_ser_reg_data_in,
    input wire logic i_read_sel,
    input wire logic i_port_sel_n,
    input wire logic i_spare_serial_in,
    output logic o_ser_reg_data_out,
    output logic o_ser_reg_data_oe,
    output logic o_rx_bit_clock,
    output logic o_rxd,
    output logic o_rx_frame_valid,
    output logic o_adc_enable,
    output logic o_xcvr_clk_div2,
    output logic o_xcvr_clk_div4
);

    // The spare serial input is not used by the four-wire port.
    logic [7:0] regs [0:31];

    logic [2:0] sclk_s;
    logic [1:0] sd_s;
    logic [1:0] rw_s;
    logic [1:0] cs_s;
    logic [1:0] pe_s;

    always_ff @(posedge i_clk) begin
        sclk_s <= {sclk_s[1:0], i_sclk};
        sd_s <= {sd_s[0], i_ser_reg_data_in};
        rw_s <= {rw_s[0], i_read_sel};
        cs_s <= {cs_s[0], i_port_sel_n};
        pe_s <= {pe_s[0], i_rx_power_enable};
    end

    logic sclk_rise;
    assign sclk_rise = sclk_s[1] & ~sclk_s[2]; // R10

    // Serial register port.
    sp_state_t st, next_st;
    logic [2:0] cnt, next_cnt;
    logic [7:0] addr, next_addr;
    logic [7:0] shreg, next_shreg;
    logic wr, next_wr;
    logic next_sd_out, next_sd_oe;
    logic [7:0] addr_full;

    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_addr = addr;
        next_shreg = shreg;
        next_wr = 1'b0;
        next_sd_out = o_ser_reg_data_out;
        next_sd_oe = o_ser_reg_data_oe;
        addr_full = {addr[6:0], sd_s[1]};
        if (cs_s[1]) begin // R14 R21
            next_st = SP_IDLE;
            next_cnt = 3'h0;
            next_sd_oe = 1'b0;
        end else begin
            unique case (st)
                SP_IDLE: begin
                    next_st = SP_ADDR;
                    next_cnt = 3'h0;
                    next_sd_oe = 1'b0; // R25
                end
                SP_ADDR: begin
                    if (sclk_rise) begin
                        next_addr = addr_full; // R8 R9
                        next_cnt = cnt + 3'h1;
                        if (cnt == `BIT_LAST) begin
                            next_st = SP_DATA;
                            if (rw_s[1]) begin // R12 R13
                                next_shreg = regs[addr_full[`IDX_HI:`IDX_LO]]; // R23
                                next_sd_out = next_shreg[7];
                                next_sd_oe = 1'b1; // R25
                            end
                        end
                    end
                end
                SP_DATA: begin
                    if (sclk_rise) begin
                        next_cnt = cnt + 3'h1;
                        if (rw_s[1]) begin
                            next_shreg = {shreg[6:0], 1'b0}; // R8
                            next_sd_out = next_shreg[7];
                        end else begin
                            next_shreg = {shreg[6:0], sd_s[1]}; // R8
                        end
                        if (cnt == `BIT_LAST) begin
                            next_st = SP_DONE;
                            next_wr = ~rw_s[1]; // R12
                            next_sd_oe = 1'b0;
                        end
                    end
                end
                SP_DONE: begin
                    next_sd_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            st <= SP_IDLE;
            cnt <= 3'h0;
            addr <= 8'h00;
            shreg <= 8'h00;
            wr <= 1'b0;
            o_ser_reg_data_out <= 1'b0;
            o_ser_reg_data_oe <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            addr <= next_addr;
            shreg <= next_shreg;
            wr <= next_wr;
            o_ser_reg_data_out <= next_sd_out;
            o_ser_reg_data_oe <= next_sd_oe;
        end
    end

    // No reset here: configuration survives master reset.
    always_ff @(posedge i_clk) begin
        if (wr) begin
            regs[addr[`IDX_HI:`IDX_LO]] <= shreg; // R18 R23
        end
    end

    // Receive enable after reset.
    logic [1:0] pe_cnt, next_pe_cnt;
    logic rx_ready;

    always_comb begin
        next_pe_cnt = pe_cnt;
        if (!pe_s[1]) begin
            next_pe_cnt = 2'h0;
        end else if (pe_cnt != `PE_HOLD) begin
            next_pe_cnt = pe_cnt + 2'h1; // R19
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pe_cnt <= 2'h0; // R17
        end else begin
            pe_cnt <= next_pe_cnt;
        end
    end

    assign rx_ready = (pe_cnt == `PE_HOLD) & pe_s[1]; // R7 R19

    // Receive port; the port select plays no part here.
    logic fv, next_fv;
    logic pend, next_pend;
    logic clk_lvl, next_clk_lvl;
    logic [3:0] hi_cnt, next_hi_cnt;
    logic next_rxd;
    logic inv;

    assign inv = regs[`CFG_INV_IDX][`CFG_INV_BIT]; // R4

    always_comb begin
        next_fv = fv;
        next_pend = 1'b0;
        next_clk_lvl = clk_lvl;
        next_hi_cnt = hi_cnt;
        next_rxd = o_rxd;
        if (!rx_ready) begin // R6 R7 R15
            next_fv = 1'b0;
            next_clk_lvl = 1'b0;
            next_hi_cnt = 4'h0;
        end else begin
            if (i_demod.start_of_frame_mark) begin
                next_fv = 1'b1; // R5 R6
            end
            if (i_demod.hdr_err) begin
                next_fv = 1'b0; // R6
            end
            if (i_demod.bit_stb && (fv || i_demod.start_of_frame_mark)) begin
                next_rxd = i_demod.bit_val; // R24
                next_pend = ~i_demod.crc_phase; // R2 R3
            end
            if (pend) begin
                next_clk_lvl = 1'b1; // R1
                next_hi_cnt = `RX_BIT_CLOCK_HI;
            end else if (hi_cnt != 4'h0) begin
                next_hi_cnt = hi_cnt - 4'h1;
                if (hi_cnt == 4'h1) begin
                    next_clk_lvl = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            fv <= 1'b0;
            pend <= 1'b0;
            clk_lvl <= 1'b0;
            hi_cnt <= 4'h0;
            o_rxd <= 1'b0;
            o_rx_frame_valid <= 1'b0;
            o_rx_bit_clock <= 1'b0;
            o_adc_enable <= 1'b0; // R17
        end else begin
            fv <= next_fv;
            pend <= next_pend;
            clk_lvl <= next_clk_lvl;
            hi_cnt <= next_hi_cnt;
            o_rxd <= next_rxd;
            o_rx_frame_valid <= next_fv;
            o_rx_bit_clock <= next_clk_lvl ^ inv; // R4
            o_adc_enable <= rx_ready; // R7
        end
    end

    // Transceiver clocks from the master clock.
    logic [1:0] div, next_div;
    assign next_div = div + 2'h1; // R20

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            div <= 2'h0;
            o_xcvr_clk_div2 <= 1'b0;
            o_xcvr_clk_div4 <= 1'b0;
        end else begin
            div <= next_div;
            o_xcvr_clk_div2 <= next_div[0];
            o_xcvr_clk_div4 <= next_div[1];
        end
    end

    a_fv_on_sfd: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
        rx_ready && i_demod.start_of_frame_mark && !i_demod.hdr_err |=> o_rx_frame_valid)
        else $error("frame valid not set on frame mark");

    a_fv_off_err: assert property (@(posedge i_clk) disable iff (!i_nrst) // R6
        i_demod.hdr_err |=> !o_rx_frame_valid)
        else $error("frame valid kept after header error");

    a_fv_off_pe: assert property (@(posedge i_clk) disable iff (!i_nrst) // R7
        !pe_s[1] |=> !o_rx_frame_valid && !o_adc_enable)
        else $error("receive active without power enable");

    a_crc_no_clk: assert property (@(posedge i_clk) disable iff (!i_nrst) // R2
        i_demod.bit_stb && i_demod.crc_phase |=> !pend)
        else $error("bit clock pulse during checksum");

    a_clk_width: assert property (@(posedge i_clk) disable iff (!i_nrst) // R1
        rx_ready && pend |=> clk_lvl [*2])
        else $error("bit clock high phase too short");

    a_addr_release: assert property (@(posedge i_clk) disable iff (!i_nrst) // R25
        st == SP_ADDR |-> !o_ser_reg_data_oe)
        else $error("data line driven during address phase");

    a_read_drive: assert property (@(posedge i_clk) disable iff (!i_nrst) // R13
        !cs_s[1] && st == SP_ADDR && sclk_rise && cnt == `BIT_LAST && rw_s[1]
        |=> o_ser_reg_data_oe && st == SP_DATA)
        else $error("read data not driven after address");

    a_cs_idle: assert property (@(posedge i_clk) disable iff (!i_nrst) // R21
        cs_s[1] |=> st == SP_IDLE && !o_ser_reg_data_oe)
        else $error("port not reset by deselect");

    a_pe_hold: assert property (@(posedge i_clk) disable iff (!i_nrst) // R19
        $rose(pe_s[1]) |-> !rx_ready ##1 !rx_ready ##1 rx_ready)
        else $error("receive resumed at wrong time");

    a_div_rate: assert property (@(posedge i_clk) disable iff (!i_nrst) // R20
        o_xcvr_clk_div4 && !$past(o_xcvr_clk_div4) |=> o_xcvr_clk_div4 ##1 !o_xcvr_clk_div4)
        else $error("divide by four clock wrong");

endmodule

// file: host_ctrl_model.sv
// Purpose: Host model that drives the four-wire serial register port.
// Assumes: Serial clock phases of four i_clk cycles each.
// Notes: A released data line toggles every cycle so a stale value cannot pass.
`timescale 1ns/10ps
module host_ctrl_model (
    input wire logic i_clk,
    input wire logic i_dev_out,
    input wire logic i_dev_oe,
    output logic o_sclk,
    output logic o_sd,
    output logic o_read_sel,
    output logic o_port_sel_n,
    output logic o_spare_serial_in
);
    logic drv = 1'b0;
    logic bit_v = 1'b0;
    logic flip = 1'b0;
    int clash = 0;
    initial begin
        o_sclk = 1'b0;
        o_read_sel = 1'b0;
        o_port_sel_n = 1'b1;
        o_spare_serial_in = 1'b0;
    end
    always @(posedge i_clk) begin
        flip <= ~flip;
        if (drv && i_dev_oe) clash++;
    end
    assign o_sd = i_dev_oe ? i_dev_out : (drv ? bit_v : flip);
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    // Four-cycle phases keep the serial clock at an eighth of i_clk.
    task automatic xfer(input bit rd, input bit sel_n, input logic [7:0] a, input logic [7:0] d,
        input int nb, output logic [7:0] q);
        logic [15:0] w;
        w = {a, d};
        q = 8'h00;
        o_port_sel_n = sel_n;
        o_read_sel = rd;
        wait_clk(4);
        for (int k = 0; k < nb; k++) begin
            drv = !(rd && k > 7);
            bit_v = w[15 - k];
            wait_clk(4);
            if (!drv) q = {q[6:0], o_sd};
            o_sclk = 1'b1;
            if (rd && k == 7) drv = 1'b0;
            wait_clk(4);
            o_sclk = 1'b0;
        end
        wait_clk(4);
        drv = 1'b0;
        o_port_sel_n = 1'b1;
        wait_clk(4);
    endtask
endmodule

// file: baseband_host_rx_ctrl_ports_bench.sv
// Purpose: Self-checking bench for the receive port and serial register port.
// Assumes: 20 MHz clock; inputs change 2 ns after the rising edge.
// Notes: Register contents are random at start, so every read follows a write.
`timescale 1ns/10ps
module baseband_host_rx_ctrl_ports_bench;
    import rx_ctrl_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pe = 1'b0;
    demod_t dm = '0;
    logic sclk, sd, rsel, psel_n, spare, dout, doe, bclk, rxd, fv, adc, d2, d4, l2, l4;
    logic inv = 1'b0;
    logic bclk_q = 1'b0;
    logic [7:0] q, a, d;
    logic exp_bits[$];
    logic got_bits[$];
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int n2, n4;
    always #25 clk = ~clk;
    baseband_host_rx_ctrl_ports DUT (.i_clk(clk), .i_nrst(nrst), .i_rx_power_enable(pe),
        .i_demod(dm), .i_sclk(sclk), .i_ser_reg_data_in(sd), .i_read_sel(rsel),
        .i_port_sel_n(psel_n), .i_spare_serial_in(spare), .o_ser_reg_data_out(dout),
        .o_ser_reg_data_oe(doe), .o_rx_bit_clock(bclk), .o_rxd(rxd), .o_rx_frame_valid(fv),
        .o_adc_enable(adc), .o_xcvr_clk_div2(d2), .o_xcvr_clk_div4(d4));
    host_ctrl_model host (.i_clk(clk), .i_dev_out(dout), .i_dev_oe(doe), .o_sclk(sclk),
        .o_sd(sd), .o_read_sel(rsel), .o_port_sel_n(psel_n), .o_spare_serial_in(spare));
    always @(posedge clk) begin
        cyc++;
        bclk_q <= bclk ^ inv;
        if (nrst && fv && !bclk_q && (bclk ^ inv)) got_bits.push_back(rxd);
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
        host.xfer(1'b0, 1'b0, wa, wd, 16, q);
    endtask
    task automatic rd(input logic [7:0] ra);
        host.xfer(1'b1, 1'b0, ra, 8'h00, 16, q);
    endtask
    // A stray bit before the mark must not clock; checksum bits ride with crc_phase high.
    task automatic frame(input int nb, input int ncrc);
        logic b;
        got_bits.delete();
        dm.bit_stb = 1'b1;
        step(1);
        dm = '0;
        step(5);
        for (int k = 0; k < nb; k++) begin
            b = 1'($urandom());
            dm.start_of_frame_mark = (k == 0);
            dm.bit_stb = 1'b1;
            dm.bit_val = b;
            dm.crc_phase = (k >= 3 && k < 3 + ncrc);
            if (!dm.crc_phase) exp_bits.push_back(b);
            step(1);
            chk_bit(fv, 1'b1);
            chk_bit(rxd, b);
            dm.start_of_frame_mark = 1'b0;
            dm.bit_stb = 1'b0;
            step(3 + $urandom_range(2));
        end
        dm = '0;
        step(4);
        chk_byte(8'(got_bits.size()), 8'(exp_bits.size()));
        foreach (exp_bits[i]) if (i < got_bits.size()) chk_bit(got_bits[i], exp_bits[i]);
        exp_bits.delete();
    endtask
    initial begin
        void'($urandom(43));
        step(12);
        chk_bit(adc, 1'b0);
        chk_bit(fv, 1'b0);
        nrst = 1'b1;
        wr(8'h04, 8'h00);
        for (int i = 0; i < 6; i++) begin
            a = {1'b0, 5'($urandom_range(2, 31)), 2'b00};
            d = 8'($urandom());
            wr(a | 8'($urandom_range(3)), d);
            rd(a | 8'($urandom_range(3)));
            chk_byte(q, d);
        end
        chk_byte(8'(host.clash), 8'h00);
        $display("test 1 register access done");
        wr(8'h40, 8'h5a);
        host.xfer(1'b0, 1'b1, 8'h40, 8'hff, 16, q);
        host.xfer(1'b0, 1'b0, 8'h40, 8'h00, 5, q);
        rd(8'h40);
        chk_byte(q, 8'h5a);
        $display("test 2 select and abort done");
        nrst = 1'b0;
        step(3);
        nrst = 1'b1;
        rd(8'h40);
        chk_byte(q, 8'h5a);
        chk_bit(bclk, 1'b0);
        $display("test 3 reset retention done");
        for (int p = 0; p < 2; p++) begin
            pe = 1'b0;
            inv = p[0];
            wr(8'h04, {7'h00, inv});
            chk_bit(bclk, inv);
            pe = 1'b1;
            step(1);
            chk_bit(adc, 1'b0);
            step(8);
            chk_bit(adc, 1'b1);
            frame(12, 3 + p);
            chk_bit(bclk, inv);
            if (p == 0) begin
                dm.hdr_err = 1'b1;
                step(1);
                dm = '0;
                chk_bit(fv, 1'b0);
            end else begin
                pe = 1'b0;
                step(5);
                chk_bit(fv, 1'b0);
                chk_bit(adc, 1'b0);
            end
            $display("test 4 frame pass %0d done", p);
        end
        n2 = 0;
        n4 = 0;
        for (int i = 0; i < 8; i++) begin
            l2 = d2;
            l4 = d4;
            step(1);
            n2 += int'(d2 !== l2);
            n4 += int'(d4 !== l4);
        end
        chk_byte(8'(n2), 8'h08);
        chk_byte(8'(n4), 8'h04);
        $display("test 5 dividers done");
        close_out();
    end
endmodule
